// >>> hw/regcfg_pkg.sv
package regcfg_pkg;
  localparam logic [7:0]  CMD_MIN_RAMP_MV = 8'hCE;
  localparam logic [7:0]  CMD_ISENSE_CFG  = 8'hD0;
  localparam logic [7:0]  CMD_MISC_CFG    = 8'hD1;
  localparam logic [15:0] RST_MIN_RAMP_MV = 16'h0000;
  localparam logic [15:0] RST_ISENSE_CFG  = 16'h0000;
  localparam logic [15:0] RST_MISC_CFG    = 16'h0000;

  localparam int CLK_HZ        = 25_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int BLANK_STEP_NS = 32;
  localparam logic [9:0] CLK_STEP_NS  = 10'(CLK_PERIOD_NS);
  localparam logic [9:0] BLANK_MAX_NS = 10'h340;
  localparam logic [4:0] BLANK_MAX_CODE = 5'h1A;
  localparam logic [3:0] RUN_MAX        = 4'hF;

  localparam int BLANK_HI  = 15;
  localparam int BLANK_LO  = 11;
  localparam int FCNT_HI   = 10;
  localparam int FCNT_LO   = 8;
  localparam int METHOD_HI = 3;
  localparam int METHOD_LO = 2;
  localparam int RANGE_HI  = 1;
  localparam int RANGE_LO  = 0;
  localparam int MDUTY_HI  = 15;
  localparam int MDUTY_LO  = 11;
  localparam int MDUTY_EN  = 7;
  localparam int VSET_SEL  = 5;
  localparam int LS_DIS    = 3;
  localparam int PG_PP     = 2;
  localparam int EXT_TEMP  = 1;
  localparam int EXT_FAULT = 0;
  localparam logic [1:0] SENSE_SPS = 2'h3;

  typedef struct packed {
    logic [15:0] min_mv;
    logic [15:0] isense;
    logic [15:0] misc;
  } cfg_t;

  typedef struct packed {
    logic [9:0] blank_ns;
    logic       oc_seen;
    logic       uc_seen;
    logic [3:0] oc_run;
    logic [3:0] uc_run;
    logic       oc_fault;
    logic       uc_fault;
    logic       sw_q;
  } chan_t;

  typedef struct packed {
    logic [15:0] target_mv;
    logic [8:0]  duty;
    logic        ls_drive;
    logic        pg_out;
    logic        pg_oe;
    logic        smart_power_stage_sensing;
    logic [1:0]  range;
    logic        ext_comp;
    logic        temp_ext;
  } pout_t;
endpackage

// >>> hw/regulator_sense_and_misc_config.sv
`timescale 1ns/1ps
`default_nettype none
module regulator_sense_and_misc_config #(
  parameter int PAGES = 2
) (
  input  wire logic                    i_mclk,
  input  wire logic                    i_rstn,
  input  wire logic                    i_ce,
  input  wire logic                    i_cmd_valid,
  input  wire logic                    i_cmd_write,
  input  wire logic [7:0]              i_cmd_page,
  input  wire logic [7:0]              i_cmd_code,
  input  wire logic [15:0]             i_cmd_wdata,
  output logic                         o_cmd_done,
  output logic                         o_cmd_ack,
  output logic [15:0]                  o_cmd_rdata,
  input  wire logic [PAGES-1:0]        i_sw_edge,
  input  wire logic [PAGES-1:0]        i_oc_cmp,
  input  wire logic [PAGES-1:0]        i_uc_cmp,
  input  wire logic [PAGES-1:0]        i_ramp_active,
  input  wire logic [PAGES-1:0][15:0]  i_setpoint_a,
  input  wire logic [PAGES-1:0][15:0]  i_setpoint_b,
  input  wire logic [PAGES-1:0][8:0]   i_duty_req,
  input  wire logic [PAGES-1:0]        i_out_enabled,
  input  wire logic [PAGES-1:0]        i_ls_pwm,
  input  wire logic [PAGES-1:0]        i_pg_level,
  output logic [PAGES-1:0][15:0]       o_target_mv,
  output logic [PAGES-1:0][8:0]        o_duty,
  output logic [PAGES-1:0]             o_ls_drive,
  output logic [PAGES-1:0]             o_pg_out,
  output logic [PAGES-1:0]             o_pg_oe,
  output logic [PAGES-1:0]             o_oc_fault,
  output logic [PAGES-1:0]             o_uc_fault,
  output logic [PAGES-1:0]             o_sense_sps,
  output logic [PAGES-1:0][1:0]        o_adc_range,
  output logic [PAGES-1:0]             o_ext_temp_comp,
  output logic [PAGES-1:0]             o_temp_ext_sel
);

  typedef struct packed {
    regcfg_pkg::cfg_t  [PAGES-1:0] cfg;
    regcfg_pkg::chan_t [PAGES-1:0] ch;
    regcfg_pkg::pout_t [PAGES-1:0] po;
    logic [PAGES-1:0]              sw_s1;
    logic [PAGES-1:0]              sw_s2;
    logic [PAGES-1:0]              oc_s1;
    logic [PAGES-1:0]              oc_s2;
    logic [PAGES-1:0]              uc_s1;
    logic [PAGES-1:0]              uc_s2;
    logic                          done;
    logic                          ack;
    logic [15:0]                   rdata;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  always_comb begin
    logic       start;
    logic [4:0] code;
    logic [3:0] need;
    logic [3:0] run;
    logic [8:0] min_duty;
    logic [15:0] sel_mv;
    regcfg_pkg::cfg_t c;
    start    = 1'b0;
    code     = '0;
    need     = '0;
    run      = '0;
    min_duty = '0;
    sel_mv   = '0;
    c        = '0;
    nxt_state       = state_ff;
    nxt_state.done  = 1'b0;
    nxt_state.sw_s1 = i_sw_edge;
    nxt_state.sw_s2 = state_ff.sw_s1;
    nxt_state.oc_s1 = i_oc_cmp;
    nxt_state.oc_s2 = state_ff.oc_s1;
    nxt_state.uc_s1 = i_uc_cmp;
    nxt_state.uc_s2 = state_ff.uc_s1;
    if (i_cmd_valid) begin
      nxt_state.done  = 1'b1;
      nxt_state.ack   = 1'b0;
      nxt_state.rdata = '0;
      if (i_cmd_page < 8'(PAGES)) begin
        if (i_cmd_code == regcfg_pkg::CMD_MIN_RAMP_MV) begin
          nxt_state.ack   = 1'b1;
          nxt_state.rdata = state_ff.cfg[i_cmd_page].min_mv;
          if (i_cmd_write) begin
            nxt_state.cfg[i_cmd_page].min_mv = i_cmd_wdata;
          end
        end else if (i_cmd_code == regcfg_pkg::CMD_ISENSE_CFG) begin
          nxt_state.ack   = 1'b1;
          nxt_state.rdata = state_ff.cfg[i_cmd_page].isense;
          if (i_cmd_write) begin
            nxt_state.cfg[i_cmd_page].isense = i_cmd_wdata;
          end
        end else if (i_cmd_code == regcfg_pkg::CMD_MISC_CFG) begin
          nxt_state.ack   = 1'b1;
          nxt_state.rdata = state_ff.cfg[i_cmd_page].misc;
          if (i_cmd_write) begin
            nxt_state.cfg[i_cmd_page].misc = i_cmd_wdata;
          end
        end
      end
    end
    for (int p = 0; p < PAGES; p++) begin
      c     = state_ff.cfg[p];
      start = state_ff.sw_s2[p] & ~state_ff.ch[p].sw_q;
      nxt_state.ch[p].sw_q = state_ff.sw_s2[p];
      code = c.isense[regcfg_pkg::BLANK_HI:regcfg_pkg::BLANK_LO];
      if (code > regcfg_pkg::BLANK_MAX_CODE) begin
        code = regcfg_pkg::BLANK_MAX_CODE;
      end
      need = {c.isense[regcfg_pkg::FCNT_HI:regcfg_pkg::FCNT_LO], 1'b1};
      if (start) begin
        nxt_state.ch[p].blank_ns = 10'(code) * 10'(regcfg_pkg::BLANK_STEP_NS);
        nxt_state.ch[p].oc_seen  = 1'b0;
        nxt_state.ch[p].uc_seen  = 1'b0;
        run = state_ff.ch[p].oc_run;
        if (state_ff.ch[p].oc_seen) begin
          if (run != regcfg_pkg::RUN_MAX) begin
            run = run + 4'h1;
          end
        end else begin
          run = '0;
        end
        nxt_state.ch[p].oc_run   = run;
        nxt_state.ch[p].oc_fault = state_ff.ch[p].oc_seen && (run >= need);
        run = state_ff.ch[p].uc_run;
        if (state_ff.ch[p].uc_seen) begin
          if (run != regcfg_pkg::RUN_MAX) begin
            run = run + 4'h1;
          end
        end else begin
          run = '0;
        end
        nxt_state.ch[p].uc_run   = run;
        nxt_state.ch[p].uc_fault = state_ff.ch[p].uc_seen && (run >= need);
      end else begin
        if (state_ff.ch[p].blank_ns > regcfg_pkg::CLK_STEP_NS) begin
          nxt_state.ch[p].blank_ns = state_ff.ch[p].blank_ns - regcfg_pkg::CLK_STEP_NS;
        end else begin
          nxt_state.ch[p].blank_ns = '0;
        end
        if (state_ff.ch[p].blank_ns == '0) begin
          if (state_ff.oc_s2[p]) begin
            nxt_state.ch[p].oc_seen = 1'b1;
          end
          if (state_ff.uc_s2[p]) begin
            nxt_state.ch[p].uc_seen = 1'b1;
          end
        end
      end
      sel_mv = c.misc[regcfg_pkg::VSET_SEL] ? i_setpoint_b[p] : i_setpoint_a[p];
      if (i_ramp_active[p] && (sel_mv < c.min_mv)) begin
        sel_mv = c.min_mv;
      end
      nxt_state.po[p].target_mv = sel_mv;
      min_duty = 9'({6'({1'b0, c.misc[regcfg_pkg::MDUTY_HI:regcfg_pkg::MDUTY_LO]}) + 6'h01, 1'b0});
      if (c.misc[regcfg_pkg::MDUTY_EN] && (i_duty_req[p] < min_duty)) begin
        nxt_state.po[p].duty = min_duty;
      end else begin
        nxt_state.po[p].duty = i_duty_req[p];
      end
      nxt_state.po[p].ls_drive = i_out_enabled[p] ? i_ls_pwm[p] : c.misc[regcfg_pkg::LS_DIS];
      if (c.misc[regcfg_pkg::PG_PP]) begin
        nxt_state.po[p].pg_out = i_pg_level[p];
        nxt_state.po[p].pg_oe  = 1'b1;
      end else begin
        nxt_state.po[p].pg_out = 1'b0;
        nxt_state.po[p].pg_oe  = ~i_pg_level[p];
      end
      nxt_state.po[p].smart_power_stage_sensing =
        c.isense[regcfg_pkg::METHOD_HI:regcfg_pkg::METHOD_LO] == regcfg_pkg::SENSE_SPS;
      nxt_state.po[p].range    = c.isense[regcfg_pkg::RANGE_HI:regcfg_pkg::RANGE_LO];
      nxt_state.po[p].ext_comp = c.misc[regcfg_pkg::EXT_TEMP];
      nxt_state.po[p].temp_ext = c.misc[regcfg_pkg::EXT_FAULT];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      state_ff <= '0;
    end else if (i_ce) begin
      state_ff <= nxt_state;
    end
  end

  assign o_cmd_done  = state_ff.done;
  assign o_cmd_ack   = state_ff.ack;
  assign o_cmd_rdata = state_ff.rdata;

  for (genvar g = 0; g < PAGES; g++) begin : g_out
    assign o_target_mv[g]     = state_ff.po[g].target_mv;
    assign o_duty[g]          = state_ff.po[g].duty;
    assign o_ls_drive[g]      = state_ff.po[g].ls_drive;
    assign o_pg_out[g]        = state_ff.po[g].pg_out;
    assign o_pg_oe[g]         = state_ff.po[g].pg_oe;
    assign o_oc_fault[g]      = state_ff.ch[g].oc_fault;
    assign o_uc_fault[g]      = state_ff.ch[g].uc_fault;
    assign o_sense_sps[g]     = state_ff.po[g].smart_power_stage_sensing;
    assign o_adc_range[g]     = state_ff.po[g].range;
    assign o_ext_temp_comp[g] = state_ff.po[g].ext_comp;
    assign o_temp_ext_sel[g]  = state_ff.po[g].temp_ext;
  end

  property p_ramp_floor;
    @(posedge i_mclk) disable iff (!i_rstn)
      i_ce && i_ramp_active[0] |=> o_target_mv[0] >= $past(state_ff.cfg[0].min_mv);
  endproperty
  a_ramp_floor: assert property (p_ramp_floor) else $error("ramp target below floor");

  property p_vset;
    @(posedge i_mclk) disable iff (!i_rstn)
      i_ce && !i_ramp_active[0] |=> o_target_mv[0] == ($past(state_ff.cfg[0].misc[5])
        ? $past(i_setpoint_b[0]) : $past(i_setpoint_a[0]));
  endproperty
  a_vset: assert property (p_vset) else $error("setpoint source wrong");

  property p_blank_gate;
    @(posedge i_mclk) disable iff (!i_rstn)
      $rose(state_ff.ch[0].oc_seen) |-> $past(state_ff.ch[0].blank_ns) == '0;
  endproperty
  a_blank_gate: assert property (p_blank_gate) else $error("sampled inside blanking");

  property p_blank_max;
    @(posedge i_mclk) disable iff (!i_rstn)
      state_ff.ch[0].blank_ns <= regcfg_pkg::BLANK_MAX_NS;
  endproperty
  a_blank_max: assert property (p_blank_max) else $error("blanking above maximum");

  property p_fault_count;
    @(posedge i_mclk) disable iff (!i_rstn)
      state_ff.ch[0].oc_fault && $past(i_ce && state_ff.sw_s2[0] && !state_ff.ch[0].sw_q)
        |-> state_ff.ch[0].oc_run >= $past({state_ff.cfg[0].isense[10:8], 1'b1});
  endproperty
  a_fault_count: assert property (p_fault_count) else $error("fault before count");

  property p_run_reset;
    @(posedge i_mclk) disable iff (!i_rstn)
      i_ce && state_ff.sw_s2[0] && !state_ff.ch[0].sw_q && !state_ff.ch[0].oc_seen
        |=> state_ff.ch[0].oc_run == '0 && !o_oc_fault[0];
  endproperty
  a_run_reset: assert property (p_run_reset) else $error("run kept without event");

  property p_sps;
    @(posedge i_mclk) disable iff (!i_rstn)
      i_ce |=> o_sense_sps[0] == ($past(state_ff.cfg[0].isense[3:2]) == regcfg_pkg::SENSE_SPS);
  endproperty
  a_sps: assert property (p_sps) else $error("sensing method mismatch");

  property p_range;
    @(posedge i_mclk) disable iff (!i_rstn)
      i_ce |=> o_adc_range[0] == $past(state_ff.cfg[0].isense[1:0]);
  endproperty
  a_range: assert property (p_range) else $error("range mismatch");

  property p_min_duty;
    @(posedge i_mclk) disable iff (!i_rstn)
      i_ce && state_ff.cfg[0].misc[7]
        |=> o_duty[0] >= {3'h0, $past(state_ff.cfg[0].misc[15:11]) + 6'h01, 1'b0};
  endproperty
  a_min_duty: assert property (p_min_duty) else $error("duty below minimum");

  property p_duty_off;
    @(posedge i_mclk) disable iff (!i_rstn)
      i_ce && !state_ff.cfg[0].misc[7] |=> o_duty[0] == $past(i_duty_req[0]);
  endproperty
  a_duty_off: assert property (p_duty_off) else $error("clamp while disabled");

  property p_pg_od;
    @(posedge i_mclk) disable iff (!i_rstn)
      i_ce && !state_ff.cfg[0].misc[2] |=> !o_pg_out[0] && (o_pg_oe[0] == !$past(i_pg_level[0]));
  endproperty
  a_pg_od: assert property (p_pg_od) else $error("open-drain drive wrong");

  property p_ls_off;
    @(posedge i_mclk) disable iff (!i_rstn)
      i_ce && !i_out_enabled[0] |=> o_ls_drive[0] == $past(state_ff.cfg[0].misc[3]);
  endproperty
  a_ls_off: assert property (p_ls_off) else $error("disabled drive level wrong");

  property p_page_iso;
    @(posedge i_mclk) disable iff (!i_rstn)
      i_ce && i_cmd_valid && i_cmd_write && i_cmd_page != 8'h00 |=> $stable(state_ff.cfg[0]);
  endproperty
  a_page_iso: assert property (p_page_iso) else $error("other page disturbed");

endmodule
`default_nettype wire

// >>> test/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        i_mclk,
  input  wire logic        i_done,
  input  wire logic        i_ack,
  input  wire logic [15:0] i_rdata,
  output logic             o_valid,
  output logic             o_write,
  output logic [7:0]       o_page,
  output logic [7:0]       o_code,
  output logic [15:0]      o_wdata
);
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_page  = 8'h00;
    o_code  = 8'h00;
    o_wdata = 16'h0000;
  end
  task automatic xfer(input logic w, input logic [7:0] pg, input logic [7:0] cd,
                      input logic [15:0] wd, output logic ak, output logic [15:0] rd);
    int n;
    n = 0;
    o_valid = 1'b1;
    o_write = w;
    o_page  = pg;
    o_code  = cd;
    o_wdata = wd;
    @(posedge i_mclk);
    #1;
    o_valid = 1'b0;
    o_page  = ~pg;
    o_wdata = ~wd;
    while (i_done !== 1'b1 && n < 4) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    ak = (i_done === 1'b1) ? i_ack : 1'bx;
    rd = i_rdata;
    @(posedge i_mclk);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> test/regulator_sense_and_misc_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module regulator_sense_and_misc_config_tb;
  logic                  mclk = 1'b0;
  logic                  rstn = 1'b0;
  logic                  ce   = 1'b1;
  logic                  valid, wr, done, ack;
  logic [7:0]            page, code;
  logic [15:0]           wdata, rdata;
  logic [1:0]            sw = 2'h0, oc = 2'h0, uc = 2'h0, ramp = 2'h0;
  logic [1:0]            en = 2'h0, ls = 2'h3, pgl = 2'h3;
  logic [1:0][15:0]      spa = '0, spb = '0, tgt;
  logic [1:0][8:0]       dreq = '0, duty;
  logic [1:0]            lsd, pgo, pgoe, ocf, ucf, smart_power_stage_sensing, extc, tsel;
  logic [1:0][1:0]       rng;
  logic                  ak;
  logic [15:0]           rd;
  logic [55:0]           rows [12];
  int                    mismatches = 0;
  int                    checks = 0;

  always #20 mclk = ~mclk;

  host_model u_host (.i_mclk(mclk), .i_done(done), .i_ack(ack), .i_rdata(rdata),
    .o_valid(valid), .o_write(wr), .o_page(page), .o_code(code), .o_wdata(wdata));

  regulator_sense_and_misc_config #(.PAGES(2)) i_dut (
    .i_mclk(mclk), .i_rstn(rstn), .i_ce(ce), .i_cmd_valid(valid),
    .i_cmd_write(wr), .i_cmd_page(page), .i_cmd_code(code), .i_cmd_wdata(wdata),
    .o_cmd_done(done), .o_cmd_ack(ack), .o_cmd_rdata(rdata), .i_sw_edge(sw),
    .i_oc_cmp(oc), .i_uc_cmp(uc), .i_ramp_active(ramp), .i_setpoint_a(spa),
    .i_setpoint_b(spb), .i_duty_req(dreq), .i_out_enabled(en), .i_ls_pwm(ls),
    .i_pg_level(pgl), .o_target_mv(tgt), .o_duty(duty), .o_ls_drive(lsd),
    .o_pg_out(pgo), .o_pg_oe(pgoe), .o_oc_fault(ocf), .o_uc_fault(ucf),
    .o_sense_sps(smart_power_stage_sensing), .o_adc_range(rng), .o_ext_temp_comp(extc),
    .o_temp_ext_sel(tsel));

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic pulse();
    sw[0] = 1'b1;
    step(3);
    sw[0] = 1'b0;
    step(5);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    // fields: write, page, code, wdata, ack, old value
    rows = '{56'h0_00_CE_0000_1_0000, 56'h0_00_D0_0000_1_0000,
             56'h0_01_D1_0000_1_0000, 56'h1_00_D1_0084_1_0000,
             56'h1_01_D1_1234_1_0000, 56'h0_00_D1_0000_1_0084,
             56'h0_01_D1_0000_1_1234, 56'h1_00_D2_5555_0_0000,
             56'h1_02_D0_5555_0_0000, 56'h0_00_D0_0000_1_0000,
             56'h1_00_CE_0320_1_0000, 56'h0_00_CE_0000_1_0320};
    step(6);
    rstn = 1'b1;
    chk("duty", 16'h0000, {7'h00, duty[0]});
    step(1);
    foreach (rows[i]) begin
      u_host.xfer(rows[i][52], rows[i][51:44], rows[i][43:36], rows[i][35:20], ak, rd);
      chk("ack", {15'h0000, rows[i][16]}, {15'h0000, ak});
      chk("rdata", rows[i][15:0], rd);
    end
    $display("test rows done");
    spa[0] = 16'h03E8;
    spb[0] = 16'h04B0;
    dreq[0] = 9'h00A;
    u_host.xfer(1'b1, 8'h00, 8'hD1, 16'hF8A6, ak, rd);
    step(1);
    chk("duty", 16'h0040, {7'h00, duty[0]});
    chk("target", 16'h04B0, tgt[0]);
    chk("ls", 16'h0000, {15'h0000, lsd[0]});
    chk("pg", 16'h0003, {14'h0000, pgo[0], pgoe[0]});
    chk("temp", 16'h0002, {14'h0000, extc[0], tsel[0]});
    spa[0] = 16'h01F4;
    ramp[0] = 1'b1;
    u_host.xfer(1'b1, 8'h00, 8'hD1, 16'h0009, ak, rd);
    step(1);
    chk("duty", 16'h000A, {7'h00, duty[0]});
    chk("target", 16'h0320, tgt[0]);
    chk("ls", 16'h0001, {15'h0000, lsd[0]});
    chk("pg", 16'h0000, {14'h0000, pgo[0], pgoe[0]});
    chk("temp", 16'h0001, {14'h0000, extc[0], tsel[0]});
    chk("p1 ls", 16'h0000, {15'h0000, lsd[1]});
    $display("test misc done");
    ce = 1'b0;
    dreq[0] = 9'h015;
    step(2);
    chk("frozen duty", 16'h000A, {7'h00, duty[0]});
    ce = 1'b1;
    step(2);
    chk("duty", 16'h0015, {7'h00, duty[0]});
    $display("test enable done");
    u_host.xfer(1'b1, 8'h00, 8'hD0, 16'h010E, ak, rd);
    step(1);
    chk("sps", 16'h0001, {15'h0000, smart_power_stage_sensing[0]});
    chk("range", 16'h0002, {14'h0000, rng[0]});
    oc[0] = 1'b1;
    repeat (3) pulse();
    chk("fault", 16'h0000, {15'h0000, ocf[0]});
    pulse();
    chk("fault", 16'h0001, {15'h0000, ocf[0]});
    oc[0] = 1'b0;
    repeat (2) pulse();
    chk("fault", 16'h0000, {15'h0000, ocf[0]});
    chk("uc", 16'h0000, {15'h0000, ucf[0]});
    $display("test fault done");
    u_host.xfer(1'b1, 8'h00, 8'hD0, 16'hD00E, ak, rd);
    oc[0] = 1'b1;
    repeat (3) pulse();
    chk("blanked", 16'h0000, {15'h0000, ocf[0]});
    u_host.xfer(1'b1, 8'h00, 8'hD0, 16'h000E, ak, rd);
    uc[0] = 1'b1;
    repeat (2) pulse();
    chk("fault", 16'h0001, {15'h0000, ocf[0]});
    chk("uc", 16'h0001, {15'h0000, ucf[0]});
    oc[0] = 1'b0;
    uc[0] = 1'b0;
    $display("test blank done");
    rstn = 1'b0;
    step(2);
    chk("reset fault", 16'h0000, {15'h0000, ocf[0]});
    chk("reset uc", 16'h0000, {15'h0000, ucf[0]});
    chk("reset duty", 16'h0000, {7'h00, duty[0]});
    rstn = 1'b1;
    step(1);
    u_host.xfer(1'b0, 8'h00, 8'hD1, 16'h0000, ak, rd);
    chk("reset ack", 16'h0001, {15'h0000, ak});
    chk("reset rdata", 16'h0000, rd);
    $display("test reset done");
    conclude();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
